// File: hw/isaoe_core.v
// Overview of operation
// - Increment-skip-if-nonzero adds one; result to accumulator if d=0, file if d=1.
// - Nonzero increment result discards the prefetched instruction, running a no-op instead.
// - Takes one cycle, two on skip, three when skipping a two-word instruction.
// - Flushed cycles do nothing in all four phases; two for two-word skips.
// - Access bit 0 picks the access bank; 1 uses bank select register.
// - Extended set, access bit 0, address at most 95 gives indexed addressing.
// - Increment-skip-if-nonzero opcode is 0100 10da with eight-bit file address.
// - Or-literal ORs the accumulator with the literal into the accumulator.
// - Or-literal opcode upper byte 0000 1001; one word, one cycle.
// - Or-with-file ORs accumulator and file; destination bit picks the target.
// - Or-with-file opcode is 0001 00da with eight-bit file address.
// - File instructions run decode, read, process, write across four quarter phases.
`include "isaoe_consts.vh"

module isaoe_core
(
  input wire i_core_clk,
  input wire i_rstn,
  input wire [15:0] i_instr,
  input wire i_next_two_word,
  input wire i_ext_en,
  input wire [3:0] i_bank_sel,
  input wire [11:0] i_index_base,
  input wire [7:0] i_rd_data,
  output reg [1:0] o_phase_q,
  output reg [11:0] o_addr_q,
  output reg o_rd_en_q,
  output reg o_wr_en_q,
  output reg [7:0] o_wr_data_q,
  output reg [7:0] o_wreg_q,
  output reg o_flag_n_q,
  output reg o_flag_z_q,
  output reg o_skip_q,
  output reg o_nop_q
);

  wire [2:0] dec_op;
  wire dec_dest_file;
  wire dec_is_file;
  wire [7:0] dec_literal;
  wire [11:0] dec_addr;
  reg [2:0] op_q;
  reg dest_file_q;
  reg [7:0] lit_q;
  reg [1:0] flush_cnt_q;
  reg [1:0] flush_cnt_d;
  reg [7:0] result_d;
  reg skip_d;
  wire is_or;

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  isaoe_decode u_decode
  (
    .i_instr(i_instr),
    .i_ext_en(i_ext_en),
    .i_bank_sel(i_bank_sel),
    .i_index_base(i_index_base),
    .o_op(dec_op),
    .o_dest_file(dec_dest_file),
    .o_is_file(dec_is_file),
    .o_literal(dec_literal),
    .o_addr(dec_addr)
  );

  assign is_or = (op_q == `ISAOE_OP_OR_LIT) || (op_q == `ISAOE_OP_OR_FILE);

  // Process step of the third quarter
  always @*
  begin
    result_d = 8'h00;
    skip_d = 1'b0;
    case (op_q)
      `ISAOE_OP_INC_NZ:
      begin
        result_d = i_rd_data + 8'h01;
        skip_d = !is_zero(result_d);
      end
      `ISAOE_OP_INC_Z:
      begin
        result_d = i_rd_data + 8'h01;
        skip_d = is_zero(result_d);
      end
      `ISAOE_OP_OR_LIT:
      begin
        result_d = o_wreg_q | lit_q;
      end
      `ISAOE_OP_OR_FILE:
      begin
        result_d = o_wreg_q | i_rd_data;
      end
      default:
      begin
        result_d = 8'h00;
      end
    endcase
  end

  // Flushed cycle bookkeeping at the end of each cycle
  always @*
  begin
    flush_cnt_d = flush_cnt_q;
    if (o_nop_q && (flush_cnt_q != 2'h0))
    begin
      flush_cnt_d = flush_cnt_q - 2'h1;
    end
  end

  always @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      o_phase_q <= `ISAOE_Q1;
      o_addr_q <= `ISAOE_RST_ADDR;
      o_rd_en_q <= 1'b0;
      o_wr_en_q <= 1'b0;
      o_wr_data_q <= 8'h00;
      o_wreg_q <= `ISAOE_RST_WREG;
      o_flag_n_q <= 1'b0;
      o_flag_z_q <= 1'b0;
      o_skip_q <= 1'b0;
      o_nop_q <= 1'b0;
      op_q <= `ISAOE_OP_NONE;
      dest_file_q <= 1'b0;
      lit_q <= 8'h00;
      flush_cnt_q <= 2'h0;
    end
    else
    begin
      o_phase_q <= o_phase_q + 2'h1;
      case (o_phase_q)
        `ISAOE_Q1:
        begin
          // Decode; a flushed cycle takes nothing in
          if (o_nop_q)
          begin
            op_q <= `ISAOE_OP_NONE;
            o_rd_en_q <= 1'b0;
          end
          else
          begin
            op_q <= dec_op;
            dest_file_q <= dec_dest_file;
            lit_q <= dec_literal;
            o_addr_q <= dec_addr;
            o_rd_en_q <= dec_is_file;
          end
        end
        `ISAOE_Q2:
        begin
          o_rd_en_q <= 1'b0;
        end
        `ISAOE_Q3:
        begin
          // Commit result so the write lands in the fourth quarter
          if (op_q != `ISAOE_OP_NONE)
          begin
            if (dest_file_q && (op_q != `ISAOE_OP_OR_LIT))
            begin
              o_wr_en_q <= 1'b1;
              o_wr_data_q <= result_d;
            end
            else
            begin
              o_wreg_q <= result_d;
            end
            if (is_or)
            begin
              o_flag_n_q <= result_d[7];
              o_flag_z_q <= is_zero(result_d);
            end
            if (skip_d)
            begin
              o_skip_q <= 1'b1;
              flush_cnt_q <= i_next_two_word ? `ISAOE_FLUSH_TWO : `ISAOE_FLUSH_ONE;
            end
          end
        end
        `ISAOE_Q4:
        begin
          o_wr_en_q <= 1'b0;
          o_skip_q <= 1'b0;
          flush_cnt_q <= flush_cnt_d;
          o_nop_q <= (flush_cnt_d != 2'h0);
        end
        default:
        begin
          o_rd_en_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // isaoe_core

// File: hw/isaoe_consts.vh
`ifndef ISAOE_CONSTS_VH
`define ISAOE_CONSTS_VH

// Opcode match patterns
`define ISAOE_PAT_INC_NZ 6'h12
`define ISAOE_PAT_INC_Z 6'h0f
`define ISAOE_PAT_OR_FILE 6'h04
`define ISAOE_PAT_OR_LIT 8'h09

// Operand field positions
`define ISAOE_BIT_DEST 9
`define ISAOE_BIT_ACC 8

// Decoded operation codes
`define ISAOE_OP_NONE 3'h0
`define ISAOE_OP_INC_NZ 3'h1
`define ISAOE_OP_INC_Z 3'h2
`define ISAOE_OP_OR_LIT 3'h3
`define ISAOE_OP_OR_FILE 3'h4

// Quarter phases
`define ISAOE_Q1 2'h0
`define ISAOE_Q2 2'h1
`define ISAOE_Q3 2'h2
`define ISAOE_Q4 2'h3

// Addressing constants
`define ISAOE_IDX_LIMIT 8'h5f
`define ISAOE_ACC_SPLIT 8'h80
`define ISAOE_ACC_HI_BANK 4'hf
`define ISAOE_ACC_LO_BANK 4'h0

// Reset values
`define ISAOE_RST_WREG 8'h00
`define ISAOE_RST_ADDR 12'h000

// Flush counts
`define ISAOE_FLUSH_ONE 2'h1
`define ISAOE_FLUSH_TWO 2'h2

`endif

// File: hw/isaoe_decode.v
`include "isaoe_consts.vh"

module isaoe_decode
(
  input wire [15:0] i_instr,
  input wire i_ext_en,
  input wire [3:0] i_bank_sel,
  input wire [11:0] i_index_base,
  output reg [2:0] o_op,
  output wire o_dest_file,
  output wire o_is_file,
  output wire [7:0] o_literal,
  output reg [11:0] o_addr
);

  wire acc_bit;
  wire [7:0] fadr;

  assign acc_bit = i_instr[`ISAOE_BIT_ACC];
  assign fadr = i_instr[7:0];
  assign o_literal = i_instr[7:0];
  assign o_dest_file = i_instr[`ISAOE_BIT_DEST];
  assign o_is_file = (o_op != `ISAOE_OP_NONE) && (o_op != `ISAOE_OP_OR_LIT);

  always @*
  begin
    o_op = `ISAOE_OP_NONE;
    if (i_instr[15:10] == `ISAOE_PAT_INC_NZ)
    begin
      o_op = `ISAOE_OP_INC_NZ;
    end
    else if (i_instr[15:10] == `ISAOE_PAT_INC_Z)
    begin
      o_op = `ISAOE_OP_INC_Z;
    end
    else if (i_instr[15:10] == `ISAOE_PAT_OR_FILE)
    begin
      o_op = `ISAOE_OP_OR_FILE;
    end
    else if (i_instr[15:8] == `ISAOE_PAT_OR_LIT)
    begin
      o_op = `ISAOE_OP_OR_LIT;
    end
  end

  always @*
  begin
    if (acc_bit)
    begin
      o_addr = {i_bank_sel, fadr};
    end
    else if (i_ext_en && (fadr <= `ISAOE_IDX_LIMIT))
    begin
      o_addr = i_index_base + {4'h0, fadr};
    end
    else if (fadr < `ISAOE_ACC_SPLIT)
    begin
      o_addr = {`ISAOE_ACC_LO_BANK, fadr};
    end
    else
    begin
      o_addr = {`ISAOE_ACC_HI_BANK, fadr};
    end
  end

endmodule // isaoe_decode

// File: dv/isaoe_sva.sv
module isaoe_sva
(
  input logic i_core_clk,
  input logic i_rstn,
  input logic [15:0] i_instr,
  input logic i_next_two_word,
  input logic i_ext_en,
  input logic [3:0] i_bank_sel,
  input logic [11:0] i_index_base,
  input logic [7:0] i_rd_data,
  input logic [1:0] o_phase_q,
  input logic [11:0] o_addr_q,
  input logic o_rd_en_q,
  input logic o_wr_en_q,
  input logic [7:0] o_wr_data_q,
  input logic [7:0] o_wreg_q,
  input logic o_flag_n_q,
  input logic o_flag_z_q,
  input logic o_skip_q,
  input logic o_nop_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  wire take = o_phase_q == 2'h0 && !o_nop_q;
  wire [5:0] opc = i_instr[15:10];
  wire orl = take && i_instr[15:8] == 8'h09;
  wire fop = take && (opc == 6'h12 || opc == 6'h04 || opc == 6'h0f);
  a_phase_step: assert property (1 |=> o_phase_q == $past(o_phase_q) + 2'h1)
    else $error("phase did not advance");
  a_rd_in_q2: assert property (o_rd_en_q |-> o_phase_q == 2'h1 && $past(fop))
    else $error("read strobe out of place");
  a_nop_quiet: assert property (o_nop_q |-> !o_rd_en_q && !o_wr_en_q && !o_skip_q)
    else $error("activity in flushed cycle");
  a_skip_one: assert property (o_skip_q && !$past(i_next_two_word) |=> o_nop_q [*4] ##1 !o_nop_q)
    else $error("single flush length wrong");
  a_skip_two: assert property (o_skip_q && $past(i_next_two_word) |=> o_nop_q [*8] ##1 !o_nop_q)
    else $error("double flush length wrong");
  a_or_lit: assert property (orl |=> !o_rd_en_q ##2 o_wreg_q == ($past(o_wreg_q, 3) | $past(i_instr[7:0], 3)))
    else $error("or literal result wrong");
  a_or_flags: assert property (orl || take && opc == 6'h04 && !i_instr[9] |-> ##3 o_flag_z_q == (o_wreg_q == 8'h00) && o_flag_n_q == o_wreg_q[7])
    else $error("or flags wrong");
  a_inc_flags: assert property (take && opc == 6'h12 |-> ##3 $stable({o_flag_n_q, o_flag_z_q}))
    else $error("increment touched flags");
  a_inc_write: assert property (take && opc == 6'h12 && i_instr[9] |-> ##3 o_wr_en_q && o_wr_data_q == $past(i_rd_data) + 8'h01 && o_skip_q == ($past(i_rd_data) != 8'hff))
    else $error("increment write or skip wrong");
  a_bank_addr: assert property (fop && i_instr[8] |=> o_addr_q == {$past(i_bank_sel), $past(i_instr[7:0])})
    else $error("banked address wrong");
  a_index_addr: assert property (fop && !i_instr[8] && i_ext_en && i_instr[7:0] <= 8'h5f |=> o_addr_q == $past(i_index_base) + {4'h0, $past(i_instr[7:0])})
    else $error("indexed address wrong");
  c_two_word: cover property (o_skip_q && $past(i_next_two_word));
  c_or_lit: cover property (orl);
  c_indexed: cover property (fop && !i_instr[8] && i_ext_en && i_instr[7:0] <= 8'h5f);
endmodule // isaoe_sva
bind isaoe_core isaoe_sva u_sva (.*);

// File: dv/isaoe_mem.sv
module isaoe_mem
(
  input logic i_core_clk,
  input logic i_rd_en,
  input logic i_wr_en,
  input logic [11:0] i_addr,
  input logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:4095];
  initial
  begin
    o_rd_data = 8'h00;
    for (int i = 0; i < 4096; i++)
      mem[i] = i[0] ? 8'hff : i[7:0];
  end
  always @(posedge i_core_clk)
  begin
    o_rd_data <= i_rd_en ? mem[i_addr] : ~o_rd_data;
    if (i_wr_en)
      mem[i_addr] <= i_wr_data;
  end
endmodule // isaoe_mem

// File: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, two = 0, ext = 0;
  logic [15:0] ins = 16'h0900;
  logic [3:0] bank = 4'h0;
  logic [11:0] base = 12'h000, ad;
  logic [7:0] f;
  logic [31:0] k;
  logic [5:0] op [4] = '{6'h12, 6'h04, 6'h0f, 6'h12};
  wire [7:0] rd, wdat, wreg;
  wire [11:0] addr;
  wire [1:0] ph;
  wire rde, wre, fn, fz, skp, nop;
  int seed = 72468, miscompares = 0, comparisons = 0, n = 0;
  int w = 0, fl = 0, ew, es, v, o;
  always #25 clk = ~clk;
  isaoe_core dut (.i_core_clk(clk), .i_rstn(rstn), .i_instr(ins), .i_next_two_word(two),
    .i_ext_en(ext), .i_bank_sel(bank), .i_index_base(base), .i_rd_data(rd),
    .o_phase_q(ph), .o_addr_q(addr), .o_rd_en_q(rde), .o_wr_en_q(wre), .o_wr_data_q(wdat),
    .o_wreg_q(wreg), .o_flag_n_q(fn), .o_flag_z_q(fz), .o_skip_q(skp), .o_nop_q(nop));
  isaoe_mem mem (.i_core_clk(clk), .i_rd_en(rde), .i_wr_en(wre), .i_addr(addr),
    .i_wr_data(wdat), .o_rd_data(rd));
  task cmp(input string s, input int e, input logic [7:0] g);
    comparisons++;
    if (g !== e[7:0])
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e[7:0], g);
    end
  endtask
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (rstn && ph === 2'h3 && nop === 1'b0 && n > 0)
    begin
      cmp("wreg", w, wreg);
      cmp("wr_en", ew, {7'h00, wre});
      if (ew)
        cmp("wr_data", v, wdat);
      cmp("skip", es, {7'h00, skp});
      cmp("flags", fl, {6'h00, fn, fz});
    end
    if (rstn && ph === 2'h0 && nop === 1'b0)
    begin
      f = ins[7:0];
      ad = !ins[8] && ext && f <= 8'h5f ? base + f : !ins[8] ? {{4{f[7]}}, f} : {bank, f};
      o = ins[15:10] == 6'h04 || ins[15:8] == 8'h09;
      v = ins[15:10] == 6'h04 ? mem.mem[ad] | w : o ? f | w : (mem.mem[ad] + 1) & 255;
      es = ins[15:10] == 6'h12 ? v != 0 : ins[15:10] == 6'h0f ? v == 0 : 0;
      ew = ins[15:8] != 8'h09 && ins[9];
      w = ew ? w : v;
      fl = o ? (v >> 6 & 2) | (v == 0) : fl;
      n++;
      k = $random(seed);
      ins <= k[17:16] == 2'h3 ? {8'h09, k[7:0]} : {op[k[17:16]], k[9:0]};
      two <= k[20];
      ext <= k[21];
      bank <= k[25:22];
      base <= k[31:20];
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wait (n == 400);
    repeat (16) @(posedge clk);
    $display("random instruction test done");
    final_report;
  end
  initial
  begin
    #1000000;
    miscompares++;
    final_report;
  end
endmodule // testbench
